// ---- src/interlock_pkg.sv ----
// constants shared by the interlock and performance monitor block
package interlock_pkg;

  // instruction classes seen at issue
  localparam logic [4:0] CL_OTHER     = 5'h00;
  localparam logic [4:0] CL_WAIT      = 5'h01;
  localparam logic [4:0] CL_SYSCTL    = 5'h02; // sysctl move-to, tlb ops
  localparam logic [4:0] CL_CACHE     = 5'h03;
  localparam logic [4:0] CL_JUMP_BR   = 5'h04; // jump_class, cond branch
  localparam logic [4:0] CL_BR_LIKELY = 5'h05;
  localparam logic [4:0] CL_MULTIPLY_TO_HILO_ACC  = 5'h06; // multiply_to_hilo family
  localparam logic [4:0] CL_MUL3      = 5'h07; // three_operand_multiply
  localparam logic [4:0] CL_DIV       = 5'h08;
  localparam logic [4:0] CL_HILO_RD   = 5'h09; // read_hi, read_lo
  localparam logic [4:0] CL_HILO_WR   = 5'h0A; // write_hi, write_lo
  localparam logic [4:0] CL_SYS_RD    = 5'h0B; // move_from_sysctl_coproc
  localparam logic [4:0] CL_LOAD      = 5'h0C;
  localparam logic [4:0] CL_MED_DMUL  = 5'h0D; // dual_halfword multiply, mac
  localparam logic [4:0] CL_MED_ONE   = 5'h0E; // acc, sad, max/min, ld..
  localparam logic [4:0] CL_MED_M2I   = 5'h0F; // media_to_integer_move
  localparam logic [4:0] CL_MED_OTHER = 5'h10;

  // penalty cycles
  localparam logic [5:0] PEN_SYSCTL    = 6'h03;
  localparam logic [5:0] PEN_CACHE     = 6'h01;
  localparam logic [5:0] PEN_BR_WRONG  = 6'h03;
  localparam logic [5:0] PEN_BL_MISS_T = 6'h03;
  localparam logic [5:0] PEN_BL_MISS_N = 6'h01;
  localparam logic [5:0] PEN_BL_PT_N   = 6'h04;
  localparam logic [5:0] PEN_BL_PN_T   = 6'h03;
  localparam logic [5:0] PEN_MULDIV    = 6'h03;
  localparam logic [5:0] PEN_RAW       = 6'h03;
  localparam logic [5:0] PEN_DMUL      = 6'h02;
  localparam logic [5:0] PEN_MEDIA     = 6'h01;
  localparam logic [5:0] DIV_MUL_MIN   = 6'h03;
  localparam logic [5:0] DIV_MUL_MAX   = 6'h22;
  localparam logic [5:0] DIV_HILO_MIN  = 6'h01;
  localparam logic [5:0] DIV_HILO_MAX  = 6'h21;

  // register byte offsets
  localparam logic [7:0] OFS_IDENT = 8'h00;
  localparam logic [7:0] OFS_RES0  = 8'h10;
  localparam logic [7:0] OFS_RES1  = 8'h14;
  localparam logic [7:0] OFS_RES2  = 8'h18;
  localparam logic [7:0] OFS_CTRL  = 8'h1C;

  // monitor control fields
  localparam int CTRL_EN_BIT  = 8;
  localparam int CTRL_SEL_LSB = 12;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CNT_RESET  = 32'h0000_0000;

  // event indices
  localparam int EV_ICMISS  = 0;
  localparam int EV_DCMISS  = 1;
  localparam int EV_ISSUED  = 2;
  localparam int EV_DISCARD = 3;
  localparam int EV_FREEZE  = 4;
  localparam int EV_CYCLE   = 5;

  typedef enum logic [2:0] {
    ST_RUN  = 3'b001,
    ST_LOCK = 3'b010,
    ST_WAIT = 3'b100
  } pipe_state_t;

endpackage

// ---- src/cpu_interlock_perf_monitor.sv ----
// pipeline interlock control with performance monitor registers
`timescale 1ns/1ps

// Functional notes
// - no hazard: one instruction issued every clock
// - wait instruction holds the pipeline until an interrupt arrives
// - sysctl move-to or tlb op: 3 interlock cycles after it
// - cache op: 1 interlock cycle after it
// - jump/branch: 0 if prediction right or miss untaken, else 3
// - branch-likely: 0, 3, 1, 4 or 3 cycles by prediction case
// - multiply family then multiply-divide op or hi/lo move: 3 cycles
// - mul3, hi/lo read, sysctl read, load, m2i: 3 cycles on dependency
// - divide then multiply or divide: 3 to 34 cycles by operands
// - divide then hi/lo read: 1 to 33 cycles; others none
// - dual halfword multiply or mac then dependent media op: 2 cycles
// - media acc, sad, minmax, load, i2m, extract: 1 cycle dependent
// - monitor counts six event kinds
// - control bit 8 starts and stops monitoring
// - control bits 15..12 choose the counted event pair
// - counts readable from three result registers
// - monitor registers only reachable in privileged mode
// - identification register returns a fixed code
module cpu_interlock_and_perf_monitor
  import interlock_pkg::*;
#(
  parameter logic [31:0] IDENT_CODE = 32'h0A5A_0001 // arbitrary value
)(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [3:0]  hprot,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        instr_valid,
  input  wire logic [4:0]  cur_class,
  input  wire logic [4:0]  nxt_class,
  input  wire logic        raw_dep,
  input  wire logic        target_hit,
  input  wire logic        target_pred_taken,
  input  wire logic        br_taken,
  input  wire logic [5:0]  div_extra,
  input  wire logic        irq_pin,
  input  wire logic        icache_miss,
  input  wire logic        dcache_miss,
  input  wire logic        discard,
  output logic             pipe_hold_q,
  output logic             issue_ok_q
);

  function automatic logic is_media(input logic [4:0] c);
    is_media = (c == CL_MED_DMUL) || (c == CL_MED_ONE) ||
               (c == CL_MED_M2I) || (c == CL_MED_OTHER);
  endfunction

  function automatic logic is_muldiv(input logic [4:0] c);
    is_muldiv = (c == CL_MULTIPLY_TO_HILO_ACC) || (c == CL_MUL3) || (c == CL_DIV) ||
                (c == CL_HILO_RD) || (c == CL_HILO_WR);
  endfunction

  function automatic logic [5:0] clamp(input logic [5:0] v,
                                       input logic [5:0] lo,
                                       input logic [5:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  function automatic logic [5:0] penalty(
    input logic [4:0] c, input logic [4:0] n, input logic raw,
    input logic hit, input logic pt, input logic tk,
    input logic [5:0] dv);
    logic [5:0] p;
    p = 6'h00;
    case (c)
      CL_SYSCTL:    p = PEN_SYSCTL;
      CL_CACHE:     p = PEN_CACHE;
      CL_JUMP_BR:
        p = ((hit && (pt == tk)) || (!hit && !tk)) ? 6'h00 : PEN_BR_WRONG;
      CL_BR_LIKELY: begin
        if (!hit)
          p = tk ? PEN_BL_MISS_T : PEN_BL_MISS_N;
        else if (pt && !tk)
          p = PEN_BL_PT_N;
        else if (!pt && tk)
          p = PEN_BL_PN_T;
        else
          p = 6'h00;
      end
      CL_MULTIPLY_TO_HILO_ACC:  p = is_muldiv(n) ? PEN_MULDIV : 6'h00;
      CL_MUL3:
        p = (is_muldiv(n) || raw) ? PEN_MULDIV : 6'h00;
      CL_DIV: begin
        if ((n == CL_MULTIPLY_TO_HILO_ACC) || (n == CL_MUL3) || (n == CL_DIV))
          p = clamp(dv, DIV_MUL_MIN, DIV_MUL_MAX);
        else if (n == CL_HILO_RD)
          p = clamp(dv, DIV_HILO_MIN, DIV_HILO_MAX);
        else
          p = 6'h00;
      end
      CL_HILO_RD, CL_SYS_RD, CL_LOAD, CL_MED_M2I:
        p = raw ? PEN_RAW : 6'h00;
      CL_MED_DMUL:  p = (raw && is_media(n)) ? PEN_DMUL : 6'h00;
      CL_MED_ONE:   p = (raw && is_media(n)) ? PEN_MEDIA : 6'h00;
      default:      p = 6'h00;
    endcase
    penalty = p;
  endfunction

  // event pair per select code; unlisted codes fall back to pair 0
  function automatic logic [1:0] pick(input logic [3:0] s,
                                      input logic [5:0] ev);
    case (s)
      4'h0:    pick = {ev[EV_ISSUED], ev[EV_CYCLE]};
      4'h1:    pick = {ev[EV_DCMISS], ev[EV_ICMISS]};
      4'h2:    pick = {ev[EV_CYCLE], ev[EV_FREEZE]};
      4'h3:    pick = {ev[EV_ISSUED], ev[EV_DISCARD]};
      4'h4:    pick = {ev[EV_CYCLE], ev[EV_ICMISS]};
      4'h5:    pick = {ev[EV_CYCLE], ev[EV_DCMISS]};
      default: pick = {ev[EV_ISSUED], ev[EV_CYCLE]};
    endcase
  endfunction

  // interrupt pin is asynchronous to hclk
  logic        irq_meta_q;
  logic        irq_q;
  pipe_state_t state_q;
  pipe_state_t state_d;
  logic [5:0]  cnt_q;
  logic [5:0]  cnt_d;

  wire         issue_take = instr_valid && (state_q == ST_RUN);
  wire  [5:0]  pen = penalty(cur_class, nxt_class, raw_dep, target_hit,
                             target_pred_taken, br_taken, div_extra);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_meta_q <= 1'b0;
      irq_q      <= 1'b0;
    end else begin
      irq_meta_q <= irq_pin;
      irq_q      <= irq_meta_q;
    end
  end

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      ST_RUN: begin
        if (issue_take && (cur_class == CL_WAIT)) begin
          state_d = ST_WAIT;
        end else if (issue_take && (pen != 6'h00)) begin
          state_d = ST_LOCK;
          cnt_d   = pen;
        end
      end
      ST_LOCK: begin
        cnt_d = cnt_q - 6'h01;
        if (cnt_q == 6'h01)
          state_d = ST_RUN;
      end
      ST_WAIT: begin
        if (irq_q)
          state_d = ST_RUN;
      end
      default: begin
        state_d = ST_RUN;
        cnt_d   = 6'h00;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q     <= ST_RUN;
      cnt_q       <= 6'h00;
      pipe_hold_q <= 1'b0;
      issue_ok_q  <= 1'b1;
    end else begin
      state_q     <= state_d;
      cnt_q       <= cnt_d;
      pipe_hold_q <= (state_d != ST_RUN);
      issue_ok_q  <= (state_d == ST_RUN);
    end
  end

  // register slave
  logic [31:0] ctrl_q;
  logic [31:0] ctrl_d;
  logic [31:0] res0_q;
  logic [31:0] res1_q;
  logic [31:0] res2_q;
  logic [31:0] res0_d;
  logic [31:0] res1_d;
  logic [31:0] res2_d;
  logic        wr_pend_q;
  logic [7:0]  wr_ofs_q;

  wire         acc   = hsel && htrans[1] && hready;
  wire         priv  = hprot[1];
  wire         rd_go = acc && !hwrite && priv;
  wire         wr_go = acc && hwrite && priv;
  wire  [7:0]  ofs   = {haddr[7:2], 2'b00};

  wire         w_ctrl = wr_pend_q && (wr_ofs_q == OFS_CTRL);
  wire         w_res0 = wr_pend_q && (wr_ofs_q == OFS_RES0);
  wire         w_res1 = wr_pend_q && (wr_ofs_q == OFS_RES1);
  wire         w_res2 = wr_pend_q && (wr_ofs_q == OFS_RES2);

  wire         mon_en = ctrl_q[CTRL_EN_BIT];
  wire  [3:0]  mon_sel = ctrl_q[CTRL_SEL_LSB +: 4];
  wire  [5:0]  events = {1'b1, pipe_hold_q, discard, issue_take,
                         dcache_miss, icache_miss};
  wire  [1:0]  pair = pick(mon_sel, events);

  // enable and select are the only live control bits
  assign ctrl_d = w_ctrl ? (hwdata & 32'h0000_F100) : ctrl_q;
  // a software write wins over counting in the same cycle
  assign res0_d = w_res0 ? hwdata :
                  (mon_en && pair[0]) ? res0_q + 32'h1 : res0_q;
  assign res1_d = w_res1 ? hwdata :
                  (mon_en && pair[1]) ? res1_q + 32'h1 : res1_q;
  assign res2_d = w_res2 ? hwdata :
                  mon_en ? res2_q + 32'h1 : res2_q;

  // read uses next values so a read right after a write sees it
  wire  [31:0] rd_val =
    (ofs == OFS_IDENT) ? IDENT_CODE :
    (ofs == OFS_CTRL)  ? ctrl_d :
    (ofs == OFS_RES0)  ? res0_d :
    (ofs == OFS_RES1)  ? res1_d :
    (ofs == OFS_RES2)  ? res2_d : 32'h0000_0000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_ofs_q  <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wr_pend_q <= wr_go;
      wr_ofs_q  <= ofs;
      hrdata    <= rd_go ? rd_val : 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= CTRL_RESET;
      res0_q <= CNT_RESET;
      res1_q <= CNT_RESET;
      res2_q <= CNT_RESET;
    end else begin
      ctrl_q <= ctrl_d;
      res0_q <= res0_d;
      res1_q <= res1_d;
      res2_q <= res2_d;
    end
  end

  // checks
  sysctl_lock_a: assert property (@(posedge hclk) disable iff (!hresetn)
    issue_take && (cur_class == CL_SYSCTL)
    |=> pipe_hold_q [*3] ##1 !pipe_hold_q)
    else $error("sysctl op not followed by three hold cycles");

  cache_lock_a: assert property (@(posedge hclk) disable iff (!hresetn)
    issue_take && (cur_class == CL_CACHE)
    |=> pipe_hold_q ##1 !pipe_hold_q)
    else $error("cache op not followed by one hold cycle");

  clean_issue_a: assert property (@(posedge hclk) disable iff (!hresetn)
    issue_take && (cur_class == CL_OTHER) |=> !pipe_hold_q && issue_ok_q)
    else $error("plain instruction caused a hold");

  br_penalty_a: assert property (@(posedge hclk) disable iff (!hresetn)
    issue_take && (cur_class == CL_JUMP_BR) && target_hit &&
    target_pred_taken && !br_taken
    |=> pipe_hold_q [*3] ##1 !pipe_hold_q)
    else $error("mispredicted branch penalty wrong");

  likely_pen_a: assert property (@(posedge hclk) disable iff (!hresetn)
    issue_take && (cur_class == CL_BR_LIKELY) && target_hit &&
    target_pred_taken && !br_taken
    |=> pipe_hold_q [*4] ##1 !pipe_hold_q)
    else $error("branch-likely taken-predicted penalty wrong");

  wait_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q == ST_WAIT) && !irq_q |=> pipe_hold_q)
    else $error("wait released without interrupt");

  div_range_a: assert property (@(posedge hclk) disable iff (!hresetn)
    issue_take && (cur_class == CL_DIV) && (nxt_class == CL_DIV)
    |=> pipe_hold_q [*3] ##[1:32] !pipe_hold_q)
    else $error("divide stall outside 3 to 34 cycles");

  mon_stop_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !mon_en && !wr_pend_q |=> res2_q == $past(res2_q))
    else $error("monitor counted while disabled");

  freeze_cnt_a: assert property (@(posedge hclk) disable iff (!hresetn)
    mon_en && (mon_sel == 4'h2) && pipe_hold_q && !wr_pend_q
    |=> res0_q == $past(res0_q) + 32'h1)
    else $error("freeze cycle not counted");

  user_block_a: assert property (@(posedge hclk) disable iff (!hresetn)
    acc && !hwrite && !priv |=> hrdata == 32'h0000_0000)
    else $error("unprivileged read returned data");

  ident_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_go && (ofs == OFS_IDENT) |=> hrdata == IDENT_CODE)
    else $error("identification read wrong");

endmodule // cpu_interlock_and_perf_monitor

// ---- tb/cpu_interlock_and_perf_monitor_tb.sv ----
// self-checking bench for the interlock and performance monitor block
`timescale 1ns/1ps
module cpu_interlock_and_perf_monitor_tb;
  import interlock_pkg::*;
  localparam logic [31:0] ID_VAL = 32'h0C3C_5A01; // arbitrary value
  typedef struct {
    logic [4:0] c, n;
    logic       r, h, p, t;
    logic [5:0] d;
    int         e;
  } row_t;
  logic        hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [3:0]  hprot = 4'h3;
  logic        instr_valid = 1'h0, raw_dep = 1'h0, target_hit = 1'h0;
  logic        target_pred_taken = 1'h0, br_taken = 1'h0, irq_pin = 1'h0;
  logic        icache_miss = 1'h0, dcache_miss = 1'h0, discard = 1'h0;
  logic [4:0]  cur_class = 5'h0, nxt_class = 5'h0;
  logic [5:0]  div_extra = 6'h0;
  wire logic   hreadyout, hresp, pipe_hold_q, issue_ok_q;
  wire [31:0]  hrdata;
  int          num_errors = 0, n_tests = 0, cyc = 0, cnt;
  row_t        rows[$];

  cpu_interlock_and_perf_monitor #(.IDENT_CODE(ID_VAL)) u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hprot(hprot),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .instr_valid(instr_valid),
    .cur_class(cur_class), .nxt_class(nxt_class), .raw_dep(raw_dep),
    .target_hit(target_hit), .target_pred_taken(target_pred_taken),
    .br_taken(br_taken), .div_extra(div_extra), .irq_pin(irq_pin),
    .icache_miss(icache_miss), .dcache_miss(dcache_miss),
    .discard(discard), .pipe_hold_q(pipe_hold_q), .issue_ok_q(issue_ok_q)
  );

  always #5 hclk = ~hclk;

  task automatic test_done();
    $display("errors %0d of %0d checks", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // generous ceiling: the whole sequence needs well under 2000 cycles
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      num_errors++;
      test_done();
    end
  end

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // single word transfer, held until hready is sampled high
  task automatic bus(logic w, logic [7:0] a, logic [31:0] wd);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge hclk);
    while (hreadyout !== 1'h1) @(posedge hclk);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'h1) @(posedge hclk);
    rd = hrdata;
    check("hresp", {31'h0, hresp}, 32'h0);
  endtask

  task automatic rd_chk(string name, logic [7:0] a, logic [31:0] exp);
    bus(1'h0, a, 32'h0);
    check(name, rd, exp);
  endtask

  task automatic add(logic [4:0] c, n, logic r, h, p, t, logic [5:0] d,
                     int e);
    rows.push_back('{c, n, r, h, p, t, d, e});
  endtask

  // one issue, then count the cycles that hold younger instructions
  task automatic issue(row_t x);
    cur_class <= x.c;
    nxt_class <= x.n;
    raw_dep <= x.r;
    target_hit <= x.h;
    target_pred_taken <= x.p;
    br_taken <= x.t;
    div_extra <= x.d;
    instr_valid <= 1'h1;
    @(posedge hclk);
    instr_valid <= 1'h0;
    cnt = 0;
    // values read at an edge are the ones launched by the edge before
    @(posedge hclk);
    while (pipe_hold_q === 1'h1 && cnt < 60) begin
      cnt++;
      @(posedge hclk);
    end
    check("issue_ok", {31'h0, issue_ok_q}, {31'h0, cnt < 60});
  endtask

  // counts one event pair over six cycles of stimulus, six idle cycles and two bus cycles
  task automatic mon(logic [3:0] sel, logic [4:0] cls, int iss, ic, dc,
                     dis, int e0, int e1);
    bus(1'h1, OFS_RES0, 32'h0);
    bus(1'h1, OFS_RES1, 32'h0);
    bus(1'h1, OFS_CTRL, {16'h0, sel, 12'h100});
    for (int i = 0; i < 6; i++) begin
      instr_valid <= (i < iss);
      cur_class <= cls;
      nxt_class <= CL_OTHER;
      icache_miss <= (i < ic);
      dcache_miss <= (i < dc);
      discard <= (i < dis);
      @(posedge hclk);
    end
    {instr_valid, icache_miss, dcache_miss, discard} <= 4'h0;
    repeat (6) @(posedge hclk);
    bus(1'h1, OFS_CTRL, {16'h0, sel, 12'h000});
    bus(1'h0, OFS_RES0, 32'h0);
    if (e0 >= 0) check("result0", rd, e0);
    bus(1'h0, OFS_RES1, 32'h0);
    if (e1 >= 0) check("result1", rd, e1);
  endtask

  initial begin
    add(CL_OTHER, CL_OTHER, 1, 0, 0, 0, 0, 0);
    add(CL_SYSCTL, CL_OTHER, 0, 0, 0, 0, 0, 3);
    add(CL_CACHE, CL_LOAD, 0, 0, 0, 0, 0, 1);
    add(CL_JUMP_BR, CL_OTHER, 0, 1, 1, 1, 0, 0);
    add(CL_JUMP_BR, CL_OTHER, 0, 1, 1, 0, 0, 3);
    add(CL_JUMP_BR, CL_OTHER, 0, 1, 0, 0, 0, 0);
    add(CL_JUMP_BR, CL_OTHER, 0, 1, 0, 1, 0, 3);
    add(CL_JUMP_BR, CL_OTHER, 0, 0, 0, 0, 0, 0);
    add(CL_JUMP_BR, CL_OTHER, 0, 0, 0, 1, 0, 3);
    add(CL_BR_LIKELY, CL_OTHER, 0, 1, 1, 1, 0, 0);
    add(CL_BR_LIKELY, CL_OTHER, 0, 0, 0, 1, 0, 3);
    add(CL_BR_LIKELY, CL_OTHER, 0, 0, 0, 0, 0, 1);
    add(CL_BR_LIKELY, CL_OTHER, 0, 1, 1, 0, 0, 4);
    add(CL_BR_LIKELY, CL_OTHER, 0, 1, 0, 1, 0, 3);
    add(CL_MULTIPLY_TO_HILO_ACC, CL_MULTIPLY_TO_HILO_ACC, 0, 0, 0, 0, 0, 3);
    add(CL_MULTIPLY_TO_HILO_ACC, CL_DIV, 0, 0, 0, 0, 0, 3);
    add(CL_MULTIPLY_TO_HILO_ACC, CL_HILO_RD, 0, 0, 0, 0, 0, 3);
    add(CL_MULTIPLY_TO_HILO_ACC, CL_HILO_WR, 0, 0, 0, 0, 0, 3);
    add(CL_MULTIPLY_TO_HILO_ACC, CL_OTHER, 1, 0, 0, 0, 0, 0);
    add(CL_MUL3, CL_OTHER, 1, 0, 0, 0, 0, 3);
    add(CL_MUL3, CL_OTHER, 0, 0, 0, 0, 0, 0);
    add(CL_HILO_RD, CL_OTHER, 1, 0, 0, 0, 0, 3);
    add(CL_SYS_RD, CL_OTHER, 1, 0, 0, 0, 0, 3);
    add(CL_LOAD, CL_OTHER, 1, 0, 0, 0, 0, 3);
    add(CL_MED_M2I, CL_OTHER, 1, 0, 0, 0, 0, 3);
    add(CL_DIV, CL_MULTIPLY_TO_HILO_ACC, 0, 0, 0, 0, 6'h22, 34);
    add(CL_DIV, CL_DIV, 0, 0, 0, 0, 6'h03, 3);
    add(CL_DIV, CL_HILO_RD, 0, 0, 0, 0, 6'h21, 33);
    add(CL_DIV, CL_HILO_RD, 0, 0, 0, 0, 6'h01, 1);
    add(CL_DIV, CL_OTHER, 1, 0, 0, 0, 6'h10, 0);
    add(CL_MED_DMUL, CL_MED_OTHER, 1, 0, 0, 0, 0, 2);
    add(CL_MED_DMUL, CL_OTHER, 1, 0, 0, 0, 0, 0);
    add(CL_MED_ONE, CL_MED_OTHER, 1, 0, 0, 0, 0, 1);
    add(CL_MED_ONE, CL_MED_OTHER, 0, 0, 0, 0, 0, 0);
    repeat (3) @(posedge hclk);
    hresetn <= 1'h1;
    foreach (rows[i]) begin
      issue(rows[i]);
      check("hold_cycles", cnt, rows[i].e);
    end
    @(posedge hclk);
    rd_chk("ident", OFS_IDENT, ID_VAL);
    rd_chk("ctrl_reset", OFS_CTRL, CTRL_RESET);
    rd_chk("res2_reset", OFS_RES2, CNT_RESET);
    rd_chk("unmapped", 8'h04, 32'h0);
    bus(1'h1, OFS_CTRL, 32'hFFFF_FFFF);
    rd_chk("ctrl_fields", OFS_CTRL, 32'h0000_F100);
    bus(1'h1, OFS_CTRL, 32'h0);
    hprot <= 4'h1;
    bus(1'h1, OFS_CTRL, 32'h0000_0100);
    rd_chk("user_ident", OFS_IDENT, 32'h0);
    hprot <= 4'h3;
    rd_chk("user_write", OFS_CTRL, 32'h0);
    // enabled from the edge after the control write to the disabling one
    mon(4'h0, CL_OTHER, 3, 0, 0, 0, 14, 3);
    mon(4'h1, CL_OTHER, 0, 1, 2, 0, 1, 2);
    mon(4'h2, CL_SYSCTL, 1, 0, 0, 0, 3, 14);
    mon(4'h3, CL_CACHE, 2, 0, 0, 2, 2, 1);
    // wait class must hold until the interrupt is seen
    issue('{CL_WAIT, CL_OTHER, 0, 0, 0, 0, 0, 0});
    check("wait_hold", cnt, 60);
    irq_pin <= 1'h1;
    issue('{CL_OTHER, CL_OTHER, 0, 0, 0, 0, 0, 0});
    check("wait_release", {31'h0, cnt <= 5}, 32'h1);
    irq_pin <= 1'h0;
    // reset in mid-stall clears the hold and the control register
    bus(1'h1, OFS_CTRL, 32'h0000_2100);
    cur_class <= CL_SYSCTL;
    instr_valid <= 1'h1;
    @(posedge hclk);
    instr_valid <= 1'h0;
    @(posedge hclk);
    check("mid_hold", {31'h0, pipe_hold_q}, 32'h1);
    hresetn <= 1'h0;
    @(negedge hclk);
    check("reset_hold", {31'h0, pipe_hold_q}, 32'h0);
    check("reset_issue", {31'h0, issue_ok_q}, 32'h1);
    @(posedge hclk);
    hresetn <= 1'h1;
    rd_chk("reset_ctrl", OFS_CTRL, CTRL_RESET);
    rd_chk("reset_res0", OFS_RES0, CNT_RESET);
    test_done();
  end
endmodule // cpu_interlock_and_perf_monitor_tb
